// File: include/iss_defines.svh
// Purpose: constants of the I/O stage supervisor
// Assumes: 200 MHz clock, 16 stages in four groups of four
// Notes:   filter counts are clock-enabled samples
`ifndef ISS_DEFINES_SVH
`define ISS_DEFINES_SVH

`define ISS_STAGES     16
`define ISS_GROUPS     4
`define ISS_GRP_SIZE   4
`define ISS_ADC_BITS   10
`define ISS_ADC_CH_W   5
// debounce thresholds per filter option
`define ISS_FLT_THR0   4'h0
`define ISS_FLT_THR1   4'h3
`define ISS_FLT_THR2   4'h7
`define ISS_FLT_THR3   4'hf
// supervision event indices
`define ISS_SUP_TWARN  2'h0
`define ISS_SUP_VBUV   2'h1
`define ISS_SUP_GND    2'h2
`define ISS_SUP_TSHUT  2'h3
`define ISS_FIFO_DEPTH 8

`endif

// File: include/iss_pkg.sv
// Purpose: types of the I/O stage supervisor
// Assumes: nothing
// Notes:   event code is {type, index}
package iss_pkg;
	typedef enum logic [1:0] {
		ISS_EV_NONE,
		ISS_EV_CHANGE,
		ISS_EV_OVERCUR,
		ISS_EV_SUPERV
	} iss_ev_t;
	typedef logic [5:0] iss_code_t;
endpackage

// File: hw/iss_top.sv
// Purpose: control and supervision of a 16-stage bidirectional driver device
// Assumes: all inputs synchronous to clock; host interface decoded elsewhere
// Notes:   interrupt events queue in a small pipeline drained by evt_ack
// Operation
// - direction chosen per group of four stages, shared by the group
// - debounce of pin levels and overcurrent, filter option per group
// - strap level picks parallel port or four-wire serial host interface
// - per-output flash enable gates the output with the common flash rhythm
// - inactive output-inhibit input turns every driver off at once
// - thermal warning raises interrupt; further rise forces outputs off
// - short circuit raises interrupt and stays readable as status
// - every interrupt source has an enable; status shows which events occurred
// - events queue in a pipeline so later events are kept, depth allowing
// - pin comparator level is readable always, whatever the direction
// - measurements reach the host as 10-bit conversion results
// - supply undervoltage or dropout resets all state and turns outputs off
// - driver supply undervoltage of a group turns that group's outputs off, registers kept
// - supplies and ground connection are supervised and faults reported
`timescale 1ns/1ps
`include "iss_defines.svh"
`default_nettype none

module iss_top #(
	parameter int DEPTH = `ISS_FIFO_DEPTH
) (
	input  wire logic                       clock,
	input  wire logic                       rst,
	input  wire logic                       clk_en,
	input  wire logic                       ext_reset_n,
	input  wire logic                       analog_uv,
	input  wire logic                       logic_dropout,
	input  wire logic                       serial_parallel_select,
	input  wire logic [`ISS_GROUPS-1:0]     dir_out,
	input  wire logic [2*`ISS_GROUPS-1:0]   pin_filter_sel,
	input  wire logic [2*`ISS_GROUPS-1:0]   oc_filter_sel,
	input  wire logic [`ISS_STAGES-1:0]     out_set,
	input  wire logic [`ISS_STAGES-1:0]     flash_en,
	input  wire logic                       flash_rate_in,
	input  wire logic                       output_inhibit_in,
	input  wire logic [`ISS_STAGES-1:0]     pin_level,
	input  wire logic [`ISS_STAGES-1:0]     overcurrent,
	input  wire logic [`ISS_STAGES-1:0]     temp_warn,
	input  wire logic [`ISS_STAGES-1:0]     temp_shut,
	input  wire logic [`ISS_GROUPS-1:0]     driver_supply_uv,
	input  wire logic                       ground_fault,
	input  wire logic [`ISS_STAGES-1:0]     change_ien,
	input  wire logic [`ISS_STAGES-1:0]     oc_ien,
	input  wire logic [3:0]                 superv_ien,
	input  wire logic                       evt_ack,
	input  wire logic                       adc_strobe,
	input  wire logic [`ISS_ADC_CH_W-1:0]   adc_chan_in,
	input  wire logic [`ISS_ADC_BITS-1:0]   adc_result_in,
	output logic                            host_if_serial,
	output logic [`ISS_STAGES-1:0]          drv_on,
	output logic [`ISS_STAGES-1:0]          pin_raw,
	output logic [`ISS_STAGES-1:0]          pin_state,
	output logic [`ISS_STAGES-1:0]          oc_status,
	output logic [3:0]                      superv_status,
	output logic                            irq_n,
	output logic                            evt_valid,
	output logic [5:0]                      evt_code,
	output logic                            adc_valid,
	output logic [`ISS_ADC_CH_W-1:0]        adc_chan,
	output logic [`ISS_ADC_BITS-1:0]        adc_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
		$error("iss_top: DEPTH must be a power of two of at least 2");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic                         strap_done;
		logic                         host_serial;
		logic [`ISS_STAGES-1:0]       pin_raw;
		logic [`ISS_STAGES-1:0]       pin_flt;
		logic [`ISS_STAGES-1:0][3:0]  pin_cnt;
		logic [`ISS_STAGES-1:0]       oc_flt;
		logic [`ISS_STAGES-1:0][3:0]  oc_cnt;
		logic [3:0]                   sup_prev;
		logic [`ISS_STAGES-1:0]       chg_pend;
		logic [`ISS_STAGES-1:0]       oc_pend;
		logic [3:0]                   sup_pend;
		logic [DEPTH-1:0][5:0]        mem;
		logic [AW:0]                  wr;
		logic [AW:0]                  rd;
		logic [`ISS_STAGES-1:0]       drv;
		logic                         irq_n;
		logic                         ev_valid;
		logic [5:0]                   ev_code;
		logic                         adc_valid;
		logic [`ISS_ADC_CH_W-1:0]     adc_chan;
		logic [`ISS_ADC_BITS-1:0]     adc_data;
	} iss_state_t;

	iss_state_t state_reg;
	iss_state_t state_next;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] flt_thr(input logic [1:0] sel);
		case (sel)
			2'h0: flt_thr = `ISS_FLT_THR0;
			2'h1: flt_thr = `ISS_FLT_THR1;
			2'h2: flt_thr = `ISS_FLT_THR2;
			default: flt_thr = `ISS_FLT_THR3;
		endcase
	endfunction

	// returns {filtered value, count}
	function automatic logic [4:0] debounce(input logic raw, input logic cur,
			input logic [3:0] cnt, input logic [3:0] thr);
		if (raw == cur)
			debounce = {cur, 4'h0};
		else if (cnt >= thr)
			debounce = {raw, 4'h0};
		else
			debounce = {cur, cnt + 4'h1};
	endfunction

	// lowest set bit index, valid flag in bit 4
	function automatic logic [4:0] first_set(input logic [15:0] v);
		first_set = 5'h00;
		for (int i = 15; i >= 0; i--) begin
			if (v[i])
				first_set = {1'b1, 4'(i)};
		end
	endfunction

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	logic        sreset;
	logic [3:0]  sup_now;
	logic [4:0]  pick;
	logic        fifo_full;
	logic        push;
	logic        pop;
	logic [5:0]  push_code;
	logic [15:0] chg_ev;
	logic [15:0] oc_ev;
	logic [3:0]  sup_ev;
	logic [15:0] out_grp;
	logic [15:0] uv_grp;
	logic [4:0]  tmp;

	assign sreset = !ext_reset_n || analog_uv || logic_dropout;

	always_comb begin
		state_next = state_reg;
		tmp = 5'h00;
		// strap caught once after reset release
		if (!state_reg.strap_done) begin
			state_next.strap_done  = 1'b1;
			state_next.host_serial = !serial_parallel_select;
		end
		// comparator level kept regardless of direction
		state_next.pin_raw = pin_level;
		for (int i = 0; i < 16; i++) begin
			tmp = debounce(pin_level[i], state_reg.pin_flt[i], state_reg.pin_cnt[i],
				flt_thr(pin_filter_sel[2*(i/4) +: 2]));
			state_next.pin_flt[i] = tmp[4];
			state_next.pin_cnt[i] = tmp[3:0];
			tmp = debounce(overcurrent[i], state_reg.oc_flt[i], state_reg.oc_cnt[i],
				flt_thr(oc_filter_sel[2*(i/4) +: 2]));
			state_next.oc_flt[i] = tmp[4];
			state_next.oc_cnt[i] = tmp[3:0];
			out_grp[i] = dir_out[i/4];
			uv_grp[i]  = driver_supply_uv[i/4];
		end
		// supervision levels
		sup_now = {|temp_shut, ground_fault, |driver_supply_uv, |temp_warn};
		state_next.sup_prev = sup_now;
		// enabled events: pin change on either edge, overcurrent and supervision on rise
		chg_ev = (state_next.pin_flt ^ state_reg.pin_flt) & ~out_grp & change_ien;
		oc_ev  = state_next.oc_flt & ~state_reg.oc_flt & oc_ien;
		sup_ev = sup_now & ~state_reg.sup_prev & superv_ien;
		// one pending event moves into the pipeline per cycle
		fifo_full = (state_reg.wr - state_reg.rd) == (AW+1)'(DEPTH);
		pop  = evt_ack && state_reg.ev_valid;
		push = 1'b0;
		push_code = 6'h00;
		pick = first_set({12'h000, state_reg.sup_pend});
		if (pick[4]) begin
			push_code = {iss_pkg::ISS_EV_SUPERV, pick[3:0]};
		end else begin
			pick = first_set(state_reg.oc_pend);
			if (pick[4]) begin
				push_code = {iss_pkg::ISS_EV_OVERCUR, pick[3:0]};
			end else begin
				pick = first_set(state_reg.chg_pend);
				if (pick[4])
					push_code = {iss_pkg::ISS_EV_CHANGE, pick[3:0]};
			end
		end
		push = pick[4] && !fifo_full;
		// pending bits: new event wins over the clear of a moved one
		state_next.sup_pend = state_reg.sup_pend | sup_ev;
		state_next.oc_pend  = state_reg.oc_pend | oc_ev;
		state_next.chg_pend = state_reg.chg_pend | chg_ev;
		if (push) begin
			case (iss_pkg::iss_ev_t'(push_code[5:4]))
				iss_pkg::ISS_EV_SUPERV:  state_next.sup_pend[pick[1:0]] = sup_ev[pick[1:0]];
				iss_pkg::ISS_EV_OVERCUR: state_next.oc_pend[pick[3:0]]  = oc_ev[pick[3:0]];
				iss_pkg::ISS_EV_CHANGE:  state_next.chg_pend[pick[3:0]] = chg_ev[pick[3:0]];
				default:        state_next.chg_pend = state_next.chg_pend;
			endcase
			state_next.mem[state_reg.wr[AW-1:0]] = push_code;
			state_next.wr = state_reg.wr + (AW+1)'(1);
		end
		if (pop)
			state_next.rd = state_reg.rd + (AW+1)'(1);
		state_next.ev_valid = state_next.wr != state_next.rd;
		state_next.ev_code  = state_next.mem[state_next.rd[AW-1:0]];
		state_next.irq_n    = !state_next.ev_valid;
		// driver gating: flash, direction, inhibit, thermal, supply
		state_next.drv = out_set & (~flash_en | {16{flash_rate_in}}) & out_grp;
		state_next.drv = state_next.drv & ~uv_grp;
		if (!output_inhibit_in || (|temp_shut))
			state_next.drv = 16'h0000;
		// conversion results
		state_next.adc_valid = adc_strobe;
		if (adc_strobe) begin
			state_next.adc_chan = adc_chan_in;
			state_next.adc_data = adc_result_in;
		end
		if (sreset)
			state_next = '{irq_n: 1'b1, default: '0};
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst)
			state_reg <= '{irq_n: 1'b1, default: '0};
		else if (clk_en)
			state_reg <= state_next;
	end

	// outputs straight from flops
	assign host_if_serial = state_reg.host_serial;
	assign drv_on         = state_reg.drv;
	assign pin_raw        = state_reg.pin_raw;
	assign pin_state      = state_reg.pin_flt;
	assign oc_status      = state_reg.oc_flt;
	assign superv_status  = state_reg.sup_prev;
	assign irq_n          = state_reg.irq_n;
	assign evt_valid      = state_reg.ev_valid;
	assign evt_code       = state_reg.ev_code;
	assign adc_valid      = state_reg.adc_valid;
	assign adc_chan       = state_reg.adc_chan;
	assign adc_data       = state_reg.adc_data;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	inhibit_off_a: assert property (clk_en && !output_inhibit_in |=> drv_on == 16'h0000)
		else $error("outputs on while inhibit inactive");
	thermal_off_a: assert property (clk_en && (|temp_shut) |=> drv_on == 16'h0000)
		else $error("outputs on during thermal shutdown");
	sreset_clear_a: assert property (clk_en && sreset |=> !evt_valid && irq_n && drv_on == 16'h0)
		else $error("supply reset did not clear state");
	group_dir_a: assert property (clk_en |=> (drv_on & ~{{4{$past(dir_out[3])}},
		{4{$past(dir_out[2])}}, {4{$past(dir_out[1])}}, {4{$past(dir_out[0])}}}) == 16'h0)
		else $error("driver on in an input group");
	vb_uv_off_a: assert property (clk_en && driver_supply_uv[0] |=> drv_on[3:0] == 4'h0)
		else $error("driver on under supply undervoltage");
	pin_read_a: assert property (clk_en && !sreset |=> pin_raw == $past(pin_level))
		else $error("pin level not readable");
	irq_match_a: assert property (irq_n == !evt_valid)
		else $error("interrupt line disagrees with queue");
	adc_take_a: assert property (clk_en && adc_strobe && !sreset |=> adc_valid
		&& adc_data == $past(adc_result_in))
		else $error("conversion result lost");
	no_filter_a: assert property (clk_en && !sreset && pin_filter_sel[1:0] == 2'h0
		&& pin_level[0] != pin_state[0] |=> pin_state[0] == $past(pin_level[0]))
		else $error("unfiltered group did not follow pin");
	oc_event_a: assert property (clk_en && !sreset && oc_ien[0] && overcurrent[0]
		&& oc_filter_sel[1:0] == 2'h0 && !oc_status[0] && !evt_valid
		&& superv_ien == 4'h0 ##1 (clk_en && !sreset) |=> evt_valid)
		else $error("overcurrent event not queued");

	flash_cov: cover property (clk_en && (|(drv_on & flash_en)) ##1 !(|(drv_on & flash_en)));
	queue_cov: cover property (evt_valid && !irq_n ##1 evt_valid);
	shut_cov:  cover property (clk_en && |temp_shut ##1 drv_on == 16'h0);
endmodule

`default_nettype wire

// File: bench/iss_host_model.sv
// Purpose: host model that drains the supervisor's event queue
// Assumes: registered event outputs, one clock domain
// Notes:   stall holds off every pop so that the queue can fill up
`timescale 1ns/1ps
`default_nettype none

module iss_host_model (
	input  wire logic       clock,
	input  wire logic       stall,
	input  wire logic       irq_n,
	input  wire logic       evt_valid,
	input  wire logic [5:0] evt_code,
	output logic            evt_ack
);
	// ------------------------------
	// event drain
	// ------------------------------
	logic [5:0] codes[$];

	// pop only while the low request is seen; registered inputs keep it clean
	assign evt_ack = ~irq_n & evt_valid & ~stall;

	// record each head taken, in order, for the bench to compare
	always @(posedge clock) begin
		if (evt_ack)
			codes.push_back(evt_code);
	end
endmodule

`default_nettype wire

// File: bench/io_stage_supervisor_bench.sv
// Purpose: self-checking bench of the I/O stage supervisor
// Assumes: queue depth cut to 4 so a full queue is reached quickly
// Notes:   driver outputs are checked each step against a bit model
`timescale 1ns/1ps
`default_nettype none

module io_stage_supervisor_bench;
	// ------------------------------
	// stimulus, model and instances
	// ------------------------------
	localparam int DEPTH = 4;
	logic        clock = 1'b0, rst = 1'b1, clk_en = 1'b1, ext_reset_n = 1'b1;
	logic        analog_uv = 1'b0, logic_dropout = 1'b0, serial_parallel_select = 1'b1;
	logic        flash_rate_in = 1'b0, output_inhibit_in = 1'b1, ground_fault = 1'b0;
	logic        adc_strobe = 1'b0, stall = 1'b1, evt_ack, host_if_serial, irq_n;
	logic        evt_valid, adc_valid;
	logic [3:0]  dir_out = '0, driver_supply_uv = '0, superv_ien = '0, superv_status;
	logic [7:0]  pin_filter_sel = '0, oc_filter_sel = '0;
	logic [15:0] out_set = '0, flash_en = '0, pin_level = '0, overcurrent = '0, e;
	logic [15:0] temp_warn = '0, temp_shut = '0, change_ien = '0, oc_ien = '0;
	logic [15:0] drv_on, pin_raw, pin_state, oc_status;
	logic [4:0]  adc_chan_in = '0, adc_chan;
	logic [9:0]  adc_result_in = '0, adc_data;
	logic [5:0]  evt_code;
	int          seed = 32'h419b3e68;
	int          n_errors = 0, compares = 0, i, k;
	int          exp_q[$];

	always #2.5 clock = ~clock;

	iss_top #(.DEPTH(DEPTH)) dut (
		.clock(clock), .rst(rst), .clk_en(clk_en), .ext_reset_n(ext_reset_n),
		.analog_uv(analog_uv), .logic_dropout(logic_dropout), .dir_out(dir_out),
		.serial_parallel_select(serial_parallel_select), .pin_filter_sel(pin_filter_sel),
		.oc_filter_sel(oc_filter_sel), .out_set(out_set), .flash_en(flash_en),
		.flash_rate_in(flash_rate_in), .output_inhibit_in(output_inhibit_in),
		.pin_level(pin_level), .overcurrent(overcurrent), .temp_warn(temp_warn),
		.temp_shut(temp_shut), .driver_supply_uv(driver_supply_uv), .oc_ien(oc_ien),
		.ground_fault(ground_fault), .change_ien(change_ien), .superv_ien(superv_ien),
		.evt_ack(evt_ack), .adc_strobe(adc_strobe), .adc_chan_in(adc_chan_in),
		.adc_result_in(adc_result_in), .host_if_serial(host_if_serial), .drv_on(drv_on),
		.pin_raw(pin_raw), .pin_state(pin_state), .oc_status(oc_status), .irq_n(irq_n),
		.superv_status(superv_status), .evt_valid(evt_valid), .evt_code(evt_code),
		.adc_valid(adc_valid), .adc_chan(adc_chan), .adc_data(adc_data)
	);

	iss_host_model host (
		.clock(clock), .stall(stall), .irq_n(irq_n), .evt_valid(evt_valid),
		.evt_code(evt_code), .evt_ack(evt_ack)
	);

	// ------------------------------
	// tasks and checks
	// ------------------------------
	task automatic tk(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// event codes, kept four-state so an unknown bit still fails
	task automatic chk_evt(input logic [5:0] got, input logic [5:0] exp);
		chk({10'h000, got}, {10'h000, exp});
	endtask

	// conversion results: valid flag, channel and data packed together
	task automatic chk_adc(input logic [15:0] got, input logic [15:0] exp);
		chk(got, exp);
	endtask

	// release the host, then compare each popped code in order
	task automatic drain(input int n);
		@(posedge clock) stall <= 1'b0;
		for (k = 0; k < 100 && host.codes.size() < n; k++)
			@(posedge clock);
		stall <= 1'b1;
		tk(2);
		#1;
		chk(16'(host.codes.size()), 16'(n));
		for (k = 0; k < n; k++)
			chk_evt(host.codes[k], 6'(exp_q[k]));
		chk({15'h0, irq_n}, 16'h0001);
		host.codes.delete();
		exp_q.delete();
	endtask

	task automatic give_verdict;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// a hang counts as a mismatch; the tests need about 750 cycles
	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end

	initial begin
		tk(5);
		rst <= 1'b0;
		// every reset source clears drivers; strap level re-read each time
		for (i = 0; i < 4; i++) begin
			@(posedge clock);
			serial_parallel_select <= i[0];
			{out_set, dir_out} <= 20'hfffff;
			tk(3);
			#1 chk(drv_on, 16'hffff);
			@(posedge clock);
			{rst, analog_uv, logic_dropout} <= {i == 0, i == 2, i == 3};
			ext_reset_n <= (i != 1);
			@(posedge clock);
			{rst, analog_uv, logic_dropout, ext_reset_n} <= 4'h1;
			#1 chk(drv_on, 16'h0000);
			chk({15'h0, irq_n}, 16'h0001);
			tk(1);
			#1 chk({15'h0, host_if_serial}, {15'h0, ~i[0]});
		end
		// frozen clock enable: drivers hold, strap not taken again
		@(posedge clock);
		{clk_en, ext_reset_n, serial_parallel_select} <= 3'h0;
		out_set <= 16'h0000;
		tk(3);
		#1 chk(drv_on, 16'hffff);
		@(posedge clock);
		{clk_en, ext_reset_n} <= 2'h3;
		tk(2);
		#1 chk(drv_on, 16'h0000);
		chk({15'h0, host_if_serial}, 16'h0000);
		// random driver and pin traffic against the bit model
		for (i = 0; i < 300; i++) begin
			@(posedge clock);
			out_set <= $random(seed);
			flash_en <= $random(seed);
			pin_level <= $random(seed);
			{dir_out, driver_supply_uv, flash_rate_in, output_inhibit_in} <= 10'($random(seed));
			temp_shut <= (($random(seed) & 7) == 0) ? 16'h0100 : 16'h0000;
			@(posedge clock);
			#1;
			for (k = 0; k < 16; k++)
				e[k] = out_set[k] & (~flash_en[k] | flash_rate_in) & dir_out[k/4] & ~driver_supply_uv[k/4];
			chk(drv_on, (output_inhibit_in && temp_shut == 0) ? e : 16'h0000);
			chk(pin_raw, pin_level);
		end
		@(posedge clock);
		{out_set, flash_en, pin_level, temp_shut, dir_out, driver_supply_uv} <= '0;
		output_inhibit_in <= 1'b1;
		oc_ien <= 16'hff7f;
		overcurrent <= 16'h00bf;
		for (i = 0; i < 6; i++)
			exp_q.push_back(32'h20 + i);
		tk(12);
		#1 chk(oc_status, 16'h00bf);
		chk({15'h0, irq_n}, 16'h0000);
		drain(6);
		// supervision events one at a time: warn, driver uv, ground, shutdown
		@(posedge clock) superv_ien <= 4'hf;
		for (i = 0; i < 4; i++) begin
			@(posedge clock);
			if (i == 0) temp_warn <= 16'h0008;
			if (i == 1) driver_supply_uv <= 4'h2;
			if (i == 2) ground_fault <= 1'b1;
			if (i == 3) temp_shut <= 16'h0001;
			exp_q.push_back(32'h30 + i);
			tk(4);
		end
		#1 chk({12'h0, superv_status}, 16'h000f);
		drain(4);
		@(posedge clock);
		{temp_warn, temp_shut, driver_supply_uv, ground_fault} <= '0;
		// filtered change: short glitch dropped, output group ignored
		{pin_filter_sel, change_ien, dir_out} <= {8'h04, 16'h0021, 4'h1};
		tk(4);
		pin_level <= 16'h0020;
		tk(2);
		pin_level <= 16'h0000;
		tk(10);
		#1 chk(pin_state, 16'h0000);
		@(posedge clock) pin_level <= 16'h0021;
		exp_q.push_back(32'h15);
		tk(25);
		#1 chk(pin_state, 16'h0021);
		drain(1);
		// conversion results, one single-cycle strobe every third cycle
		for (i = 0; i < 4; i++) begin
			@(posedge clock);
			{adc_strobe, adc_chan_in, adc_result_in} <= {1'b1, 15'($random(seed))};
			@(posedge clock);
			adc_strobe <= 1'b0;
			#1 chk_adc({adc_valid, adc_chan, adc_data}, {1'b1, adc_chan_in, adc_result_in});
			tk(1);
			#1 chk_adc({adc_valid, adc_chan, adc_data}, {1'b0, adc_chan_in, adc_result_in});
		end
		give_verdict();
	end
endmodule

`default_nettype wire
